// ---- logic/ats_core.v ----
// per-channel arm/trigger sequencer with auto output, trace buffer and grouping
`timescale 1ns/100ps
`default_nettype none
`include "ats_map.vh"
module ats_core (
   input wire clk, // 250 MHz instrument clock
   input wire rstn, // async reset, active low
   input wire [7:0] addr, // register byte address
   input wire [31:0] wdata, // register write data
   input wire wr, // write strobe
   input wire rd, // read strobe
   output reg [31:0] rdata_reg, // read data, cycle after rd
   input wire trig_line, // external trigger line level
   output reg out_on_reg, // source output switch
   output reg src_apply_reg, // start applying src_value_reg
   output reg [15:0] src_value_reg, // source output value
   output reg meas_go_reg, // start one measurement
   input wire meas_valid, // result block ready, one cycle
   input wire [15:0] voltage_item, // measured voltage
   input wire [15:0] current_item, // measured current
   input wire [15:0] resistance_item, // measured resistance
   input wire [15:0] remote_transient_voltage_item, // measured remote transient voltage
   input wire [7:0] status_item, // measurement status
   input wire grp_turn, // lower grouped channels have started source
   input wire grp_all_started, // every grouped channel has started source
   input wire grp_last_change, // last output change of the group, pulse
   input wire grp_meas_done, // group measurement complete
   output reg grp_src_started_reg, // this channel has started its source
   output wire [1:0] grp_id // group number, 1 or 2
);
////////////////////////////////////////////////////////////////////////
reg [13:0] ctrl_reg;
reg [7:0] srcsel_reg;
reg [15:0] cfg_reg [0:`ATS_NCFG-1];
reg [15:0] src_set_reg;
reg [`ATS_TW-1:0] rdaddr_reg;
wire [3:0] cfg_idx = addr[5:2] - 4'h3;
// only the implemented cfg words decode, the rest of the window reads zero
wire cfg_hit = (addr >= `ATS_A_CFG0) && (addr < `ATS_A_CFG0 + 4 * `ATS_NCFG) &&
               (addr[1:0] == 2'b00);
wire cmd_wr = wr && (addr == `ATS_A_CMD);
wire busy_s;
wire busy_m;
wire fire_s;
wire fire_m;
wire [15:0] arm_cnt_s;
wire [15:0] trig_cnt_s;
wire [15:0] arm_cnt_m;
wire [15:0] trig_cnt_m;
// busy instances drop the command
wire init_s = cmd_wr && wdata[`ATS_B_INIT_S] && !busy_s;
wire init_m = cmd_wr && wdata[`ATS_B_INIT_M] && !busy_m;
wire grouped = ctrl_reg[`ATS_B_GRP_EN];
assign grp_id = ctrl_reg[`ATS_B_GRP1] ? 2'd1 : 2'd2;
integer i;
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      ctrl_reg <= `ATS_CTRL_RST;
      srcsel_reg <= 8'h00;
      src_set_reg <= 16'h0000;
      rdaddr_reg <= {`ATS_TW{1'b0}};
      for (i = 0; i < `ATS_NCFG; i = i + 1)
         cfg_reg[i] <= `ATS_CFG_RST;
   end else if (wr) begin
      if (addr == `ATS_A_CTRL)
         ctrl_reg <= wdata[13:0];
      if (addr == `ATS_A_SRCSEL)
         srcsel_reg <= wdata[7:0];
      if (addr == `ATS_A_RDADDR)
         rdaddr_reg <= wdata[`ATS_TW-1:0];
      if (addr == `ATS_A_PEAK_TO_PEAK + 8'h04)
         src_set_reg <= wdata[15:0];
      if (cfg_hit)
         cfg_reg[cfg_idx] <= wdata[15:0];
   end
end
////////////////////////////////////////////////////////////////////////
// event sources: bus strobe, hardware timer, rising edge of trigger line
reg line_q_reg;
reg [15:0] tmr_reg;
wire line_rise = trig_line && !line_q_reg;
wire tmr_tick = (tmr_reg == 16'h0000);
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      line_q_reg <= 1'b0;
      tmr_reg <= 16'h0000;
   end else begin
      line_q_reg <= trig_line;
      // timer restarts on each initiation so grouped phases line up
      if (tmr_tick || init_s || init_m)
         tmr_reg <= cfg_reg[`ATS_C_PERIOD] - 16'h0001;
      else
         tmr_reg <= tmr_reg - 16'h0001;
   end
end
wire [3:0] ev;
genvar g;
generate
   for (g = 0; g < 4; g = g + 1) begin : g_ev
      wire [1:0] sel = srcsel_reg[2*g+1:2*g];
      wire bus_ev = cmd_wr && wdata[`ATS_B_BUS_ARM + (g % 2)];
      assign ev[g] = (sel == `ATS_SRC_BUS) ? bus_ev :
                     (sel == `ATS_SRC_TIMER) ? tmr_tick :
                     (sel == `ATS_SRC_LINE) ? line_rise : 1'b0;
   end
endgenerate
////////////////////////////////////////////////////////////////////////
// wait time and group ordering
reg [15:0] wait_reg;
wire wait_run = (wait_reg != 16'h0000);
// grouped: source waits its turn, measurement waits for every channel
wire hold_s = wait_run || (grouped && !grp_turn);
wire hold_m = wait_run || (grouped && !grp_all_started);
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      wait_reg <= 16'h0000;
   end else if (grouped ? grp_last_change : fire_s) begin
      wait_reg <= cfg_reg[`ATS_C_WAIT];
   end else if (wait_run) begin
      wait_reg <= wait_reg - 16'h0001;
   end
end
////////////////////////////////////////////////////////////////////////
// two independent instances, started together or apart
ats_seq u_seq_src (
   .clk(clk),
   .rstn(rstn),
   .start(init_s),
   .arm_ev(ev[0]),
   .trig_ev(ev[1]),
   .arm_n(cfg_reg[`ATS_C_ARMN_S]),
   .trig_n(cfg_reg[`ATS_C_TRGN_S]),
   .arm_dly(cfg_reg[`ATS_C_ARMDLY]),
   .trig_dly(cfg_reg[`ATS_C_TRGDLY]),
   .act_dly(cfg_reg[`ATS_C_SRCDLY]),
   .hold(hold_s),
   .busy(busy_s),
   .fire_reg(fire_s),
   .arm_cnt_reg(arm_cnt_s),
   .trig_cnt_reg(trig_cnt_s)
);
ats_seq u_seq_meas (
   .clk(clk),
   .rstn(rstn),
   .start(init_m),
   .arm_ev(ev[2]),
   .trig_ev(ev[3]),
   .arm_n(cfg_reg[`ATS_C_ARMN_M]),
   .trig_n(cfg_reg[`ATS_C_TRGN_M]),
   .arm_dly(cfg_reg[`ATS_C_ARMDLY]),
   .trig_dly(cfg_reg[`ATS_C_TRGDLY]),
   .act_dly(cfg_reg[`ATS_C_MEASDLY]),
   .hold(hold_m),
   .busy(busy_m),
   .fire_reg(fire_m),
   .arm_cnt_reg(arm_cnt_m),
   .trig_cnt_reg(trig_cnt_m)
);
////////////////////////////////////////////////////////////////////////
// output switch and device actions
reg any_busy_q_reg;
reg off_pend_reg;
reg [15:0] tstamp_reg;
reg [15:0] time_cap_reg;
wire any_busy = busy_s || busy_m;
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      out_on_reg <= 1'b0;
      any_busy_q_reg <= 1'b0;
      off_pend_reg <= 1'b0;
      src_apply_reg <= 1'b0;
      src_value_reg <= 16'h0000;
      meas_go_reg <= 1'b0;
      grp_src_started_reg <= 1'b0;
      tstamp_reg <= 16'h0000;
      time_cap_reg <= 16'h0000;
   end else begin
      any_busy_q_reg <= any_busy;
      tstamp_reg <= tstamp_reg + 16'h0001;
      src_apply_reg <= fire_s;
      meas_go_reg <= fire_m;
      if (fire_s)
         src_value_reg <= src_set_reg;
      if (fire_m)
         time_cap_reg <= tstamp_reg;
      if (init_s)
         grp_src_started_reg <= 1'b0;
      else if (fire_s)
         grp_src_started_reg <= 1'b1;
      // the switch closes on the same edge that the sequencer takes the start
      if ((init_s || init_m) && ctrl_reg[`ATS_B_AUTO_ON]) begin
         out_on_reg <= 1'b1;
         off_pend_reg <= 1'b0;
      end else if (any_busy_q_reg && !any_busy && ctrl_reg[`ATS_B_AUTO_OFF]) begin
         off_pend_reg <= 1'b1;
      end else if (off_pend_reg && (!grouped || grp_meas_done)) begin
         out_on_reg <= 1'b0;
         off_pend_reg <= 1'b0;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// trace buffer: append only, cleared by the software command or by reset
reg [95:0] trace_mem [0:`ATS_TRACE_DEPTH-1];
reg [95:0] trace_q_reg;
reg [`ATS_TW-1:0] tcount_reg;
wire tfull = (tcount_reg == `ATS_TRACE_DEPTH);
wire tclr = cmd_wr && wdata[`ATS_B_TCLR];
wire [7:0] items = ctrl_reg[`ATS_F_ITEMS];
wire [95:0] block = {items[0] ? voltage_item : 16'h0000,
                     items[1] ? current_item : 16'h0000,
                     items[2] ? resistance_item : 16'h0000,
                     items[3] ? remote_transient_voltage_item : 16'h0000,
                     items[4] ? time_cap_reg : 16'h0000,
                     items[5] ? status_item : 8'h00,
                     items[6] ? src_value_reg[7:0] : 8'h00};
wire twr = meas_valid && !tfull && !tclr;
always @(posedge clk) begin
   if (twr)
      trace_mem[tcount_reg] <= block;
   trace_q_reg <= trace_mem[rdaddr_reg];
end
////////////////////////////////////////////////////////////////////////
// running statistics on the selected item of stored blocks
reg [31:0] sum_reg;
reg [47:0] sumsq_reg;
reg [15:0] min_reg;
reg [15:0] max_reg;
reg [15:0] mean_reg;
reg [15:0] standard_deviation_reg;
wire [1:0] ssel = ctrl_reg[`ATS_F_STATSEL];
wire [15:0] sval = block[95-16*ssel -: 16];
// full-width square; a product inside a concatenation keeps only 16 bits
wire [31:0] sq_w = sval * sval;
wire [`ATS_TW-1:0] ncnt = (tcount_reg == {`ATS_TW{1'b0}}) ? 15'd1 : tcount_reg;
wire [31:0] mean_w = sum_reg / ncnt;
wire [47:0] msq_w = sumsq_reg / ncnt;
wire [47:0] var_w = msq_w - mean_w[15:0] * mean_w[15:0];
// bitwise square root; combinational, costs depth not cycles
function [15:0] isqrt;
   input [31:0] v;
   reg [15:0] r;
   integer k;
   begin
      r = 16'h0000;
      for (k = 15; k >= 0; k = k - 1)
         if ((r | (16'h0001 << k)) * (r | (16'h0001 << k)) <= v)
            r = r | (16'h0001 << k);
      isqrt = r;
   end
endfunction
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      tcount_reg <= {`ATS_TW{1'b0}};
      sum_reg <= 32'h00000000;
      sumsq_reg <= 48'h000000000000;
      min_reg <= 16'hffff;
      max_reg <= 16'h0000;
      mean_reg <= 16'h0000;
      standard_deviation_reg <= 16'h0000;
   end else begin
      mean_reg <= mean_w[15:0];
      standard_deviation_reg <= isqrt(var_w[31:0]);
      if (tclr) begin
         tcount_reg <= {`ATS_TW{1'b0}};
         sum_reg <= 32'h00000000;
         sumsq_reg <= 48'h000000000000;
         min_reg <= 16'hffff;
         max_reg <= 16'h0000;
      end else if (twr) begin
         tcount_reg <= tcount_reg + 15'd1;
         sum_reg <= sum_reg + {16'h0000, sval};
         sumsq_reg <= sumsq_reg + {16'h0000, sq_w};
         if (sval < min_reg)
            min_reg <= sval;
         if (sval > max_reg)
            max_reg <= sval;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// register read, answered in the cycle after the strobe
reg [31:0] rd_w;
always @* begin
   rd_w = 32'h00000000;
   if (cfg_hit)
      rd_w = {16'h0000, cfg_reg[cfg_idx]};
   case (addr)
      `ATS_A_CTRL: rd_w = {18'h00000, ctrl_reg};
      `ATS_A_SRCSEL: rd_w = {24'h000000, srcsel_reg};
      `ATS_A_STAT: rd_w = {arm_cnt_m[7:0], trig_cnt_m[7:0], trig_cnt_s[7:0],
                          arm_cnt_s[1:0], grp_id, tfull, out_on_reg, busy_m, busy_s};
      `ATS_A_TCOUNT: rd_w = {17'h00000, tcount_reg};
      `ATS_A_RDADDR: rd_w = {17'h00000, rdaddr_reg};
      `ATS_A_RD0: rd_w = trace_q_reg[95:64];
      `ATS_A_RD1: rd_w = trace_q_reg[63:32];
      `ATS_A_RD2: rd_w = trace_q_reg[31:0];
      `ATS_A_MEAN: rd_w = {16'h0000, mean_reg};
      `ATS_A_STANDARD_DEVIATION: rd_w = {16'h0000, standard_deviation_reg};
      `ATS_A_MIN: rd_w = {16'h0000, min_reg};
      `ATS_A_MAX: rd_w = {16'h0000, max_reg};
      `ATS_A_PEAK_TO_PEAK: rd_w = {16'h0000, max_reg - min_reg};
      `ATS_A_PEAK_TO_PEAK + 8'h04: rd_w = {16'h0000, src_set_reg};
      default: rd_w = rd_w;
   endcase
end
always @(posedge clk or negedge rstn) begin
   if (!rstn)
      rdata_reg <= 32'h00000000;
   else if (rd)
      rdata_reg <= rd_w;
   else
      rdata_reg <= 32'h00000000;
end
endmodule // ats_core
`default_nettype wire

// ---- logic/ats_map.vh ----
// register map, field positions and sizes of the arm/trigger sequencer
`ifndef ATS_MAP_VH
`define ATS_MAP_VH
`define ATS_A_CTRL 8'h00
`define ATS_A_CMD 8'h04
`define ATS_A_SRCSEL 8'h08
`define ATS_A_CFG0 8'h0c
`define ATS_NCFG 10
`define ATS_A_STAT 8'h40
`define ATS_A_TCOUNT 8'h44
`define ATS_A_RDADDR 8'h48
`define ATS_A_RD0 8'h4c
`define ATS_A_RD1 8'h50
`define ATS_A_RD2 8'h54
`define ATS_A_MEAN 8'h60
`define ATS_A_STANDARD_DEVIATION 8'h64
`define ATS_A_MIN 8'h68
`define ATS_A_MAX 8'h6c
`define ATS_A_PEAK_TO_PEAK 8'h70
// cfg word indices, offset = ATS_A_CFG0 + 4*index
`define ATS_C_ARMN_S 0
`define ATS_C_TRGN_S 1
`define ATS_C_ARMN_M 2
`define ATS_C_TRGN_M 3
`define ATS_C_ARMDLY 4
`define ATS_C_TRGDLY 5
`define ATS_C_SRCDLY 6
`define ATS_C_MEASDLY 7
`define ATS_C_WAIT 8
`define ATS_C_PERIOD 9
`define ATS_CFG_RST 16'h0001
// ctrl bits
`define ATS_B_AUTO_ON 0
`define ATS_B_AUTO_OFF 1
`define ATS_B_GRP_EN 2
`define ATS_B_GRP1 3
`define ATS_F_ITEMS 11:4
`define ATS_F_STATSEL 13:12
`define ATS_CTRL_RST 14'h07f0
// command bits (write only, self clearing)
`define ATS_B_INIT_S 0
`define ATS_B_INIT_M 1
`define ATS_B_BUS_ARM 2
`define ATS_B_BUS_TRG 3
`define ATS_B_TCLR 4
// trigger source codes
`define ATS_SRC_BUS 2'h0
`define ATS_SRC_TIMER 2'h1
`define ATS_SRC_LINE 2'h2
`define ATS_TRACE_DEPTH 30000
`define ATS_TW 15
`endif

// ---- logic/ats_seq.v ----
// one arm/trigger sequencer instance: idle, arm layer, trigger layer
`timescale 1ns/100ps
`default_nettype none
module ats_seq (
   input wire clk, // instrument clock
   input wire rstn, // async reset, active low
   input wire start, // accepted initiation, one cycle
   input wire arm_ev, // arm event pulse
   input wire trig_ev, // trigger event pulse
   input wire [15:0] arm_n, // programmed arm count
   input wire [15:0] trig_n, // programmed trigger count
   input wire [15:0] arm_dly, // arm delay, cycles
   input wire [15:0] trig_dly, // trigger delay, cycles
   input wire [15:0] act_dly, // source or measure delay, cycles
   input wire hold, // wait time or group order still pending
   output wire busy, // not idle
   output reg fire_reg, // device action, one cycle
   output reg [15:0] arm_cnt_reg, // arm counter
   output reg [15:0] trig_cnt_reg // trigger counter
);
localparam S_IDLE = 3'd0;
localparam S_ARM = 3'd1;
localparam S_ADLY = 3'd2;
localparam S_TRG = 3'd3;
localparam S_TDLY = 3'd4;
localparam S_ACT = 3'd5;
reg [2:0] state_reg;
reg [15:0] dly_reg;
wire dly_done = (dly_reg == 16'h0000);
assign busy = (state_reg != S_IDLE);
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      state_reg <= S_IDLE;
      dly_reg <= 16'h0000;
      fire_reg <= 1'b0;
      arm_cnt_reg <= 16'h0000;
      trig_cnt_reg <= 16'h0000;
   end else begin
      fire_reg <= 1'b0;
      if (!dly_done)
         dly_reg <= dly_reg - 16'h0001;
      case (state_reg)
         S_IDLE: begin
            if (start) begin
               state_reg <= S_ARM;
               arm_cnt_reg <= 16'h0000;
            end
         end
         S_ARM: begin
            if (arm_ev) begin
               state_reg <= S_ADLY;
               dly_reg <= arm_dly;
            end
         end
         S_ADLY: begin
            if (dly_done) begin
               state_reg <= S_TRG;
               trig_cnt_reg <= 16'h0000;
            end
         end
         S_TRG: begin
            if (trig_ev) begin
               state_reg <= S_TDLY;
               dly_reg <= trig_dly;
            end
         end
         S_TDLY: begin
            if (dly_done) begin
               state_reg <= S_ACT;
               dly_reg <= act_dly;
            end
         end
         S_ACT: begin
            // action stalls while the wait time runs
            if (dly_done && !hold) begin
               fire_reg <= 1'b1;
               trig_cnt_reg <= trig_cnt_reg + 16'h0001;
               if (trig_cnt_reg + 16'h0001 == trig_n) begin
                  arm_cnt_reg <= arm_cnt_reg + 16'h0001;
                  if (arm_cnt_reg + 16'h0001 == arm_n)
                     state_reg <= S_IDLE;
                  else
                     state_reg <= S_ARM;
               end else begin
                  state_reg <= S_TRG;
               end
            end
         end
         default: state_reg <= S_IDLE;
      endcase
   end
end
endmodule // ats_seq
`default_nettype wire

// ---- verification/ats_core_properties.sv ----
// concurrent checks on the ports of the arm/trigger sequencer core
`timescale 1ns/100ps
`default_nettype none
`include "ats_map.vh"
module ats_core_properties (
   input wire logic clk, // instrument clock
   input wire logic rstn, // async reset, active low
   input wire logic [7:0] addr, // register address
   input wire logic [31:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [31:0] rdata_reg, // read data
   input wire logic out_on_reg, // output switch
   input wire logic src_apply_reg, // source action pulse
   input wire logic [15:0] src_value_reg, // source value
   input wire logic meas_go_reg, // measure action pulse
   input wire logic grp_src_started_reg, // source started flag
   input wire logic [1:0] grp_id // group number
);
   logic init_wr;
   assign init_wr = wr && addr == `ATS_A_CMD && wdata[1:0] != 2'h0;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////////////
   a_apply_single: assert property (src_apply_reg |=> !src_apply_reg)
      else $error("source apply pulse too long");
   a_meas_single: assert property (meas_go_reg |=> !meas_go_reg)
      else $error("measure pulse too long");
   a_rdata_idle: assert property (!rd |=> rdata_reg == 32'h0)
      else $error("read data without a read");
   a_value_on_apply: assert property (!$stable(src_value_reg) |-> ##[0:1] src_apply_reg)
      else $error("source value moved outside an action");
   a_on_after_init: assert property ($rose(out_on_reg) |-> $past(init_wr) || $past(init_wr, 2))
      else $error("output switched on without an initiation");
   a_group_number: assert property (grp_id == 2'h1 || grp_id == 2'h2)
      else $error("group number out of range");
   a_group_started: assert property (src_apply_reg |-> ##[0:1] grp_src_started_reg)
      else $error("source start not flagged");
   a_off_quiet: assert property ($fell(out_on_reg) |-> !src_apply_reg && !meas_go_reg)
      else $error("output switched off during an action");
endmodule // ats_core_properties
bind ats_core ats_core_properties chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata_reg(rdata_reg), .out_on_reg(out_on_reg),
   .src_apply_reg(src_apply_reg), .src_value_reg(src_value_reg), .meas_go_reg(meas_go_reg),
   .grp_src_started_reg(grp_src_started_reg), .grp_id(grp_id));
`default_nettype wire

// ---- verification/ats_meas_model.sv ----
// behavioural measurement hardware answering each measure action
`timescale 1ns/100ps
`default_nettype none
module ats_meas_model #(parameter int LAT = 3) (
   input wire logic clk, // instrument clock
   input wire logic rstn, // async reset, active low
   input wire logic meas_go, // start one measurement
   output var logic meas_valid, // result block ready, one cycle
   output logic [15:0] voltage_item, // voltage item
   output logic [15:0] current_item, // current item
   output logic [15:0] resistance_item, // resistance item
   output logic [15:0] remote_transient_voltage_item, // remote transient voltage item
   output logic [7:0] stat // status item
);
   int cnt;
   logic [15:0] k, cyc;
   // items toggle outside the valid cycle so stale data never matches
   assign voltage_item = meas_valid ? 16'h1000 + k : ~cyc;
   assign current_item = meas_valid ? 16'h2000 + k : cyc;
   assign resistance_item = meas_valid ? 16'h3000 + k : ~cyc;
   assign remote_transient_voltage_item = meas_valid ? 16'h4000 + k : cyc;
   assign stat = meas_valid ? k[7:0] : cyc[7:0];
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         k <= 16'h0;
         cyc <= 16'h0;
         meas_valid <= 1'b0;
      end else begin
         cyc <= cyc + 16'h1;
         meas_valid <= 1'b0;
         if (meas_valid) k <= k + 16'h1;
         // odd blocks answer slowly
         if (meas_go) begin
            cnt <= LAT + (k[0] ? 4 : 0);
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
            meas_valid <= (cnt == 1);
         end
      end
   end
endmodule // ats_meas_model
`default_nettype wire

// ---- verification/test_arm_trigger_sequencer.sv ----
// self-checking bench of the arm/trigger sequencer core
`timescale 1ns/100ps
`default_nettype none
`include "ats_map.vh"
module test_arm_trigger_sequencer;
   logic clk, rstn, wr, rd, trig_line, meas_valid, exp_on;
   logic out_on_reg, src_apply_reg, meas_go_reg, grp_src_started_reg;
   logic [7:0] addr, status_item;
   logic [31:0] wdata, rdata_reg, seen;
   logic [15:0] src_value_reg, voltage_item, current_item, resistance_item;
   logic [15:0] remote_transient_voltage_item;
   logic [1:0] grp_id;
   int n_mismatch, compares, n_apply, n_block;
   ats_core dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_reg(rdata_reg), .trig_line(trig_line), .out_on_reg(out_on_reg),
      .src_apply_reg(src_apply_reg), .src_value_reg(src_value_reg), .meas_go_reg(meas_go_reg),
      .meas_valid(meas_valid), .voltage_item(voltage_item), .current_item(current_item),
      .resistance_item(resistance_item),
      .remote_transient_voltage_item(remote_transient_voltage_item),
      .status_item(status_item), .grp_turn(1'b1), .grp_all_started(1'b1),
      .grp_last_change(1'b0), .grp_meas_done(1'b1), .grp_src_started_reg(grp_src_started_reg),
      .grp_id(grp_id));
   ats_meas_model hw (.clk(clk), .rstn(rstn), .meas_go(meas_go_reg), .meas_valid(meas_valid),
      .voltage_item(voltage_item), .current_item(current_item),
      .resistance_item(resistance_item),
      .remote_transient_voltage_item(remote_transient_voltage_item),
      .stat(status_item));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (src_apply_reg === 1'b1) n_apply++;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 seen = rdata_reg;
   endtask
   // sampled mid-cycle so one pulse is seen exactly once
   task automatic wait_hi(input bit on_meas);
      int i;
      for (i = 0; (on_meas ? meas_valid : src_apply_reg) !== 1'b1; i++) begin
         if (i > 300) begin
            n_mismatch++;
            conclude();
         end
         @(negedge clk);
      end
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic run_src(input logic [15:0] an, input logic [15:0] tn, input logic [31:0] ctrl,
      input bit tmr);
      int i, j, base;
      logic [15:0] v;
      v = $urandom;
      wreg(`ATS_A_CTRL, ctrl);
      // arm from the bus strobe, trigger from the timer when tmr is set, else from the bus strobe
      wreg(`ATS_A_SRCSEL, tmr ? 32'h4 : 32'h0);
      wreg(`ATS_A_CFG0, {16'h0, an});
      wreg(`ATS_A_CFG0 + 8'h4, {16'h0, tn});
      wreg(8'h74, {16'h0, v});
      base = n_apply;
      if (ctrl[0]) exp_on = 1'b1;
      wreg(`ATS_A_CMD, 32'h1);
      repeat (2) @(posedge clk);
      check({31'h0, out_on_reg}, {31'h0, exp_on});
      for (i = 0; i < an; i++) begin
         wreg(`ATS_A_CMD, 32'h4);
         // timer triggers run on their own, so no idle gap may hide an action
         if (!tmr) repeat (8) @(posedge clk);
         for (j = 0; j < tn; j++) begin
            if (!tmr) wreg(`ATS_A_CMD, 32'h8);
            wait_hi(1'b0);
            check({16'h0, src_value_reg}, {16'h0, v});
            // re-initiation mid-run must not restart the counts
            // only while the run is still going, else it would start a new one
            if (!tmr && i == 0 && j == 0 && (an > 1 || tn > 1)) wreg(`ATS_A_CMD, 32'h1);
            if (!tmr) repeat (6) @(posedge clk);
         end
      end
      repeat (20) @(posedge clk);
      if (ctrl[1]) exp_on = 1'b0;
      check({31'h0, out_on_reg}, {31'h0, exp_on});
      check(32'(n_apply - base), 32'(an * tn));
      rreg(`ATS_A_STAT);
      check({16'h0, seen[15:0]}, {16'h0, tn[7:0], an[1:0], 2'h2, 1'b0, exp_on, 2'h0});
   endtask
   task automatic run_meas(input logic [15:0] n);
      int j;
      logic [15:0] k;
      wreg(`ATS_A_CTRL, 32'h7f0);
      wreg(`ATS_A_SRCSEL, 32'h8f);
      wreg(`ATS_A_CFG0 + 8'h8, 32'h1);
      wreg(`ATS_A_CFG0 + 8'hc, {16'h0, n});
      wreg(`ATS_A_CMD, 32'h2);
      wreg(`ATS_A_CMD, 32'h4);
      repeat (8) @(posedge clk);
      for (j = 0; j < n; j++) begin
         trig_line <= 1'b1;
         repeat (3) @(posedge clk);
         trig_line <= 1'b0;
         wait_hi(1'b1);
         n_block++;
         repeat (6) @(posedge clk);
      end
      k = 16'(n_block - 1);
      rreg(`ATS_A_TCOUNT);
      check(seen, 32'(n_block));
      wreg(`ATS_A_RDADDR, {16'h0, k});
      @(posedge clk);
      rreg(`ATS_A_RD0);
      check(seen, {16'h1000 + k, 16'h2000 + k});
      rreg(`ATS_A_MIN);
      check(seen, 32'h1000);
      rreg(`ATS_A_MAX);
      check(seen, {16'h0, 16'h1000 + k});
      rreg(`ATS_A_PEAK_TO_PEAK);
      check(seen, {16'h0, k});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int i;
      rstn = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h0;
      wdata = 32'h0;
      trig_line = 1'b0;
      exp_on = 1'b0;
      void'($urandom(32'h7269));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      rreg(`ATS_A_CTRL);
      check(seen, 32'h7f0);
      rreg(`ATS_A_CFG0);
      check(seen, 32'h1);
      rreg(`ATS_A_STAT);
      check(seen, 32'h20);
      rreg(`ATS_A_CMD);
      check(seen, 32'h0);
      rreg(8'hfc);
      check(seen, 32'h0);
      $display("test reset values done");
      run_src(16'h1, 16'h1, 32'h7f1, 1'b0);
      run_src(16'h2, 16'h3, 32'h7f2, 1'b0);
      run_src(16'h1, 16'h2, 32'h7f0, 1'b1);
      $display("test output switching done");
      for (i = 0; i < 3; i++) begin
         run_src(16'(1 + $urandom % 3), 16'(1 + $urandom % 3), 32'h7f3, 1'($urandom % 2));
      end
      $display("test random source runs done");
      run_meas(16'h3);
      run_meas(16'(1 + $urandom % 4));
      $display("test measurement trace done");
      conclude();
   end
endmodule // test_arm_trigger_sequencer
`default_nettype wire
